// ---- boost_split_if.sv ----
interface boost_split_if;
    logic [7:0] boostByte;
    logic [1:0] stage0;
    logic [1:0] stage1;
    logic [1:0] stage2;
    logic [1:0] stage3;
    modport src (output boostByte, input stage0, stage1, stage2, stage3);
    modport split (input boostByte, output stage0, stage1, stage2, stage3);
endinterface

// ---- boost_splitter.sv ----
module boost_splitter (
    boost_split_if.split bus
);
    // Stage 0 sits in the top pair, stage 3 in the bottom pair
    assign bus.stage0 = bus.boostByte[7:6];
    assign bus.stage1 = bus.boostByte[5:4];
    assign bus.stage2 = bus.boostByte[3:2];
    assign bus.stage3 = bus.boostByte[1:0];
endmodule

// ---- eq_override_consts.svh ----
`ifndef EQ_OVERRIDE_CONSTS_SVH
`define EQ_OVERRIDE_CONSTS_SVH
`define OFS_RSVD_A 8'h38
`define OFS_RSVD_B 8'h39
`define OFS_LOW_RATE_BOOST 8'h3A
`define OFS_RSVD_C 8'h3B
`define OFS_RSVD_D 8'h3C
`define OFS_RSVD_E 8'h3D
`define OFS_LOCKMON 8'h3E
`define OFS_OVERRIDE 8'h3F
`define OFS_ENTRY0 8'h40
`define OFS_ENTRY1 8'h41
`define OFS_ENTRY2 8'h42
`define OFS_ENTRY3 8'h43
`define RST_LOW_RATE_BOOST 8'h00
`define RST_RSVD_C 8'h96
`define RST_RSVD_D 8'h90
`define RST_RSVD_E 8'h30
`define RST_LOCKMON 8'h80
`define RST_OVERRIDE 8'h01
`define RST_ENTRY0 8'h00
`define RST_ENTRY1 8'h40
`define RST_ENTRY2 8'h80
`define RST_ENTRY3 8'h50
`define BIT_ADAPT_OV 5
`define BIT_INSEL_OV 4
`define BIT_OUTMUX_OV 3
`define BIT_RATE_OV 2
`define BIT_BOOST_OV 1
`define BIT_ADAPT_3G 0
`define BIT_LOCKMON 7
`define MASK_LOCKMON 8'h80
`define MASK_OVERRIDE 8'h3F
`endif

// ---- eq_override_pkg.sv ----
package eq_override_pkg;
    typedef enum logic [1:0] {
        RATE_VIDEO = 2'h0,
        RATE_ETH10G = 2'h1
    } rate_family_t;
    typedef enum logic [2:0] {
        DR_270M = 3'h0,
        DR_1G5 = 3'h1,
        DR_3G = 3'h2,
        DR_HIGH = 3'h3
    } data_rate_t;
    typedef logic [1:0] stage_boost_t [4];
endpackage

// ---- pin_override_eq_boost_regs.sv ----
`include "eq_override_consts.svh"

module pin_override_eq_boost_regs (
    input wire logic mclk,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic inOutSelPin,
    input wire logic outCtrlPin,
    input wire logic [1:0] inputRouteField,
    input wire logic [1:0] adaptModeField,
    input wire logic [1:0] outMuxField,
    input wire logic [1:0] rateSelField,
    input wire logic manualBoostEnable,
    input wire logic [7:0] manualBoost,
    input wire eq_override_pkg::data_rate_t dataRate,
    input wire logic lockDone,
    input wire logic adaptDone,
    input wire logic monitorTick,
    output logic cableToFirst,
    output logic cableToSecond,
    output logic boardToFirst,
    output logic boardToSecond,
    output logic [1:0] outMuxSel,
    output logic rateEth10g,
    output logic rateInvalid,
    output logic autoAdapt,
    output logic boostBypassPin,
    output logic useManualBoost,
    output logic [7:0] appliedBoost,
    output logic [1:0] appliedStage [4],
    output logic [7:0] adaptEntry [4],
    output logic eyeCheckReq
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] lowRateBoost;
        logic [7:0] lockMon;
        logic [7:0] override;
        logic [3:0][7:0] entry;
        logic inOutSel1;
        logic inOutSel2;
        logic outCtrl1;
        logic outCtrl2;
        logic [7:0] rdata;
        logic [7:0] boost;
        logic eyeReq;
    } state_t;
    state_t s_q;
    state_t s_d;
    logic boardSel;
    logic [1:0] route;
    logic [7:0] fixedOrAdapt;

    // ----------------------------------------------------------------
    // Steering
    // ----------------------------------------------------------------
    always_comb begin
        route = s_q.override[`BIT_INSEL_OV] ? inputRouteField
            : {s_q.inOutSel2, s_q.inOutSel2};
        boardSel = route[1];
    end
    assign cableToFirst = (route == 2'h0) || (route == 2'h1);
    assign cableToSecond = (route == 2'h0);
    assign boardToFirst = (route == 2'h3);
    assign boardToSecond = route[1];
    assign outMuxSel = s_q.override[`BIT_OUTMUX_OV] ? outMuxField
        : {s_q.outCtrl2, s_q.outCtrl2};
    assign rateEth10g = s_q.override[`BIT_RATE_OV]
        ? (rateSelField == 2'(eq_override_pkg::RATE_ETH10G)) : s_q.inOutSel2;
    assign rateInvalid = s_q.override[`BIT_RATE_OV] && rateSelField[1];
    assign autoAdapt = (s_q.override[`BIT_ADAPT_OV]
        ? (adaptModeField == 2'h1) : boardSel)
        && !(dataRate == eq_override_pkg::DR_3G
             && !s_q.override[`BIT_ADAPT_3G]);
    assign boostBypassPin = !s_q.override[`BIT_BOOST_OV] && s_q.outCtrl2;
    assign useManualBoost = s_q.override[`BIT_BOOST_OV] && manualBoostEnable;
    assign regRdata = s_q.rdata;
    assign appliedBoost = s_q.boost;
    assign eyeCheckReq = s_q.eyeReq;
    assign adaptEntry[0] = s_q.entry[0];
    assign adaptEntry[1] = s_q.entry[1];
    assign adaptEntry[2] = s_q.entry[2];
    assign adaptEntry[3] = s_q.entry[3];

    // ----------------------------------------------------------------
    // Stage split of the boost actually applied
    // ----------------------------------------------------------------
    boost_split_if split ();
    assign split.boostByte = s_q.boost;
    boost_splitter u_split (.bus(split));
    assign appliedStage[0] = split.stage0;
    assign appliedStage[1] = split.stage1;
    assign appliedStage[2] = split.stage2;
    assign appliedStage[3] = split.stage3;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.inOutSel1 = inOutSelPin;
        s_d.inOutSel2 = s_q.inOutSel1;
        s_d.outCtrl1 = outCtrlPin;
        s_d.outCtrl2 = s_q.outCtrl1;
        if (regWrite) begin
            unique case (regAddr)
                `OFS_LOW_RATE_BOOST: s_d.lowRateBoost = regWdata;
                // Only the enable bit is live; others read back zero
                `OFS_LOCKMON: s_d.lockMon = regWdata & `MASK_LOCKMON;
                `OFS_OVERRIDE: s_d.override = regWdata & `MASK_OVERRIDE;
                `OFS_ENTRY0, `OFS_ENTRY1, `OFS_ENTRY2, `OFS_ENTRY3:
                    s_d.entry[regAddr[1:0]] = regWdata;
                default: ;
            endcase
        end
        s_d.rdata = 8'h00;
        if (regRead) begin
            unique case (regAddr)
                `OFS_LOW_RATE_BOOST: s_d.rdata = s_q.lowRateBoost;
                `OFS_RSVD_C: s_d.rdata = `RST_RSVD_C;
                `OFS_RSVD_D: s_d.rdata = `RST_RSVD_D;
                `OFS_RSVD_E: s_d.rdata = `RST_RSVD_E;
                `OFS_LOCKMON: s_d.rdata = s_q.lockMon;
                `OFS_OVERRIDE: s_d.rdata = s_q.override;
                `OFS_ENTRY0, `OFS_ENTRY1, `OFS_ENTRY2, `OFS_ENTRY3:
                    s_d.rdata = s_q.entry[regAddr[1:0]];
                default: s_d.rdata = 8'h00;
            endcase
        end
        // Fixed byte at low rates, and at 3G when the BIT_ADAPT_3G override bit is clear
        fixedOrAdapt = s_q.entry[0];
        if (dataRate == eq_override_pkg::DR_270M
            || dataRate == eq_override_pkg::DR_1G5
            || (dataRate == eq_override_pkg::DR_3G
                && !s_q.override[`BIT_ADAPT_3G]))
            fixedOrAdapt = s_q.lowRateBoost;
        s_d.boost = useManualBoost ? manualBoost : fixedOrAdapt;
        s_d.eyeReq = s_q.lockMon[`BIT_LOCKMON] && lockDone && adaptDone
            && monitorTick;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.lowRateBoost <= `RST_LOW_RATE_BOOST;
            s_q.lockMon <= `RST_LOCKMON;
            s_q.override <= `RST_OVERRIDE;
            s_q.entry[0] <= `RST_ENTRY0;
            s_q.entry[1] <= `RST_ENTRY1;
            s_q.entry[2] <= `RST_ENTRY2;
            s_q.entry[3] <= `RST_ENTRY3;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence ovWrite(logic [7:0] d);
        regWrite && regAddr == `OFS_OVERRIDE && regWdata == d;
    endsequence
    a_override_readback: assert property (
        ovWrite(8'hFF) ##1 !regWrite ##1 regRead && regAddr == `OFS_OVERRIDE
        |=> regRdata == `MASK_OVERRIDE)
        else $error("override readback wrong");
    a_rsvd_c_value: assert property (
        regRead && regAddr == `OFS_RSVD_C |=> regRdata == `RST_RSVD_C)
        else $error("reserved read wrong");
    a_route_strap: assert property (
        !s_q.override[`BIT_INSEL_OV] |-> boardToSecond == s_q.inOutSel2)
        else $error("strap route wrong");
    a_route_both: assert property (
        cableToSecond |-> cableToFirst && !boardToFirst)
        else $error("route decode wrong");
    a_outmux_field: assert property (
        s_q.override[`BIT_OUTMUX_OV] |-> outMuxSel == outMuxField)
        else $error("output mux wrong");
    a_rate_invalid: assert property (
        rateInvalid |-> s_q.override[`BIT_RATE_OV] && !rateEth10g)
        else $error("rate invalid wrong");
    a_adapt_3g_off: assert property (
        dataRate == eq_override_pkg::DR_3G && !s_q.override[0]
        |-> !autoAdapt) else $error("3G adapt not blocked");
    a_fixed_boost: assert property (
        dataRate == eq_override_pkg::DR_270M && !useManualBoost
        |=> appliedBoost == $past(s_q.lowRateBoost))
        else $error("fixed boost not applied");
    a_stage_split: assert property (
        appliedStage[0] == appliedBoost[7:6]
        && appliedStage[3] == appliedBoost[1:0])
        else $error("stage split wrong");
    a_eye_gate: assert property (
        eyeCheckReq |-> $past(lockDone) && $past(s_q.lockMon[7]))
        else $error("eye check unguarded");
    a_boost_pin: assert property (
        s_q.override[1] |-> !boostBypassPin)
        else $error("bypass pin not overridden");
    a_adapt_ov: assert property (
        s_q.override[5] && adaptModeField == 2'h0 |-> !autoAdapt)
        else $error("adapt override ignored");
    a_rate_strap: assert property (
        !s_q.override[2] |-> rateEth10g == s_q.inOutSel2)
        else $error("rate strap wrong");
    a_entry_write: assert property (
        regWrite && regAddr == `OFS_ENTRY3
        |=> adaptEntry[3] == $past(regWdata))
        else $error("entry write lost");
endmodule

// ---- pin_override_eq_boost_regs_bench.sv ----
module pin_override_eq_boost_regs_bench;
timeunit 1ns;
timeprecision 1ps;
// --------------------------------------------------------------------
// Signals and design under test
// --------------------------------------------------------------------
logic mclk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, manualBoost = 8'h00;
logic inOutSelPin = 1'b0, outCtrlPin = 1'b0, manualBoostEnable = 1'b0;
logic [1:0] inputRouteField = 2'h0, adaptModeField = 2'h0;
logic [1:0] outMuxField = 2'h0, rateSelField = 2'h0, outMuxSel;
eq_override_pkg::data_rate_t dataRate = eq_override_pkg::DR_270M;
logic lockDone = 1'b0, adaptDone = 1'b0, monitorTick = 1'b0;
logic cableToFirst, cableToSecond, boardToFirst, boardToSecond;
logic rateEth10g, rateInvalid, autoAdapt, boostBypassPin, useManualBoost;
logic eyeCheckReq, eyeExp = 1'b0;
logic [7:0] appliedBoost;
logic [1:0] appliedStage [4];
logic [7:0] adaptEntry [4];
logic [7:0] m [8'h38:8'h43];
logic [31:0] seed = 32'hDDBB4468;
int numErrors = 0, nTests = 0;

pin_override_eq_boost_regs dut (.mclk(mclk), .rst(rst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .inOutSelPin(inOutSelPin),
    .outCtrlPin(outCtrlPin), .inputRouteField(inputRouteField),
    .adaptModeField(adaptModeField), .outMuxField(outMuxField),
    .rateSelField(rateSelField), .manualBoostEnable(manualBoostEnable),
    .manualBoost(manualBoost), .dataRate(dataRate), .lockDone(lockDone),
    .adaptDone(adaptDone), .monitorTick(monitorTick),
    .cableToFirst(cableToFirst), .cableToSecond(cableToSecond),
    .boardToFirst(boardToFirst), .boardToSecond(boardToSecond),
    .outMuxSel(outMuxSel), .rateEth10g(rateEth10g),
    .rateInvalid(rateInvalid), .autoAdapt(autoAdapt),
    .boostBypassPin(boostBypassPin), .useManualBoost(useManualBoost),
    .appliedBoost(appliedBoost), .appliedStage(appliedStage),
    .adaptEntry(adaptEntry), .eyeCheckReq(eyeCheckReq));

always #20 mclk = ~mclk;

// --------------------------------------------------------------------
// Helpers
// --------------------------------------------------------------------
function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction

// Writable bits per address; reserved places take nothing
function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
        8'h3A, 8'h40, 8'h41, 8'h42, 8'h43: return 8'hFF;
        8'h3E: return 8'h80;
        8'h3F: return 8'h3F;
        default: return 8'h00;
    endcase
endfunction

function automatic logic [7:0] expRead(input logic [7:0] a);
    if (a >= 8'h38 && a <= 8'h43) return m[a];
    return 8'h00;
endfunction

function automatic logic [3:0] route(input logic [1:0] r);
    return {~r[1], ~r[1] & ~r[0], r[1] & r[0], r[1]};
endfunction

task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
        numErrors++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
endtask

task automatic conclude();
    $display("checks %0d errors %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
endtask

task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
    if (a >= 8'h38 && a <= 8'h43) m[a] = (m[a] & ~wmask(a)) | (d & wmask(a));
endtask

task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    chk(regRdata, expRead(a));
endtask

task automatic checkOuts();
    logic [7:0] ov;
    logic [1:0] rt;
    logic lowRate;
    logic gate3g;
    logic [7:0] eb;
    logic [3:0] rtGot;
    logic [1:0] mx;
    logic eth;
    logic aa;
    ov = m[8'h3F];
    rt = ov[4] ? inputRouteField : {2{inOutSelPin}};
    gate3g = dataRate == eq_override_pkg::DR_3G && !ov[0];
    lowRate = dataRate < eq_override_pkg::DR_3G || gate3g;
    // Above the low rates the adaptation engine is outside; entry 0 stands in
    eb = lowRate ? m[8'h3A] : m[8'h40];
    // Manual boost outranks the rate-based choice
    if (ov[1] && manualBoostEnable) eb = manualBoost;
    rtGot = {cableToFirst, cableToSecond, boardToFirst, boardToSecond};
    mx = ov[3] ? outMuxField : {2{outCtrlPin}};
    eth = ov[2] ? rateSelField == 2'h1 : inOutSelPin;
    aa = (ov[5] ? adaptModeField == 2'h1 : rt[1]) && !gate3g;
    chk({4'h0, rtGot}, {4'h0, route(rt)});
    chk({6'h0, outMuxSel}, {6'h0, mx});
    chk({7'h0, rateEth10g}, {7'h0, eth});
    chk({7'h0, rateInvalid}, {7'h0, ov[2] & rateSelField[1]});
    chk({7'h0, autoAdapt}, {7'h0, aa});
    chk({7'h0, boostBypassPin}, {7'h0, !ov[1] & outCtrlPin});
    chk({7'h0, useManualBoost}, {7'h0, ov[1] & manualBoostEnable});
    chk(appliedBoost, eb);
    for (int i = 0; i < 4; i++) begin
        chk({6'h0, appliedStage[i]}, {6'h0, eb[7-2*i -: 2]});
        chk(adaptEntry[i], m[8'h40 + i]);
    end
endtask

always @(negedge mclk) begin
    if (!rst) begin
        chk({7'h0, eyeCheckReq}, {7'h0, eyeExp});
        eyeExp = m[8'h3E][7] & lockDone & adaptDone & monitorTick;
    end
end

initial begin
    #1000000;
    numErrors++;
    conclude();
end

// --------------------------------------------------------------------
// Main sequence
// --------------------------------------------------------------------
initial begin
    logic [31:0] r;
    m = '{8'h00, 8'h00, 8'h00, 8'h96, 8'h90, 8'h30, 8'h80, 8'h01,
          8'h00, 8'h40, 8'h80, 8'h50};
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 8'h36; a <= 8'h44; a++) rd(8'(a));
    wr(8'h3F, 8'hFF);
    rd(8'h3F);
    wr(8'h3E, 8'h7F);
    rd(8'h3E);
    for (int a = 8'h36; a <= 8'h44; a++) begin
        wr(8'(a), 8'(rnd() >> 8));
        rd(8'(a));
    end
    for (int k = 0; k < 120; k++) begin
        r = rnd();
        if (r[31:30] == 2'h0) wr(8'h3F, r[29:22]);
        if (r[21:20] == 2'h0) wr(8'h3E, r[19:12]);
        if (r[19:18] == 2'h0) wr(8'h3A, r[17:10]);
        if (r[17:16] == 2'h0) wr(8'h40 + 8'(r[1:0]), r[15:8]);
        r = rnd();
        @(posedge mclk);
        inOutSelPin <= r[0];
        outCtrlPin <= r[1];
        inputRouteField <= r[3:2];
        adaptModeField <= r[5:4];
        outMuxField <= r[7:6];
        rateSelField <= r[9:8];
        manualBoostEnable <= r[10];
        manualBoost <= r[18:11];
        dataRate <= eq_override_pkg::data_rate_t'(r[20:19]);
        lockDone <= r[21] | r[22];
        adaptDone <= r[23] | r[24];
        monitorTick <= r[25];
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        checkOuts();
    end
    conclude();
end
endmodule
